//--- design/bfr_fault_recovery.sv
// bus fault recording and return-from-exception recovery core
`timescale 1ns/1ns
module bfr_fault_recovery
    import bfr_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // fault report from the bus controller
    input  wire logic        flt_valid,
    input  wire logic        flt_exc,
    input  wire logic        flt_vec_fetch,
    input  wire logic        flt_multi_register_move,
    input  wire logic        flt_rel_wr,
    input  wire logic        flt_half2,
    input  wire logic [31:0] flt_addr,
    input  wire logic        flt_rw,
    input  wire logic        flt_rm,
    input  wire logic        flt_ifetch,
    input  wire logic [2:0]  flt_fc,
    input  wire logic [1:0]  flt_szc,
    input  wire logic [1:0]  flt_siz,
    input  wire logic [31:0] flt_dbuf,
    input  wire logic [7:0]  multi_register_move_cnt,
    // pending exceptions at fault time
    input  wire logic        pend_trace,
    input  wire logic        pend_bp_hi,
    input  wire logic        pend_bp_lo,
    // machine state at fault time
    input  wire logic [31:0] cur_pc,
    input  wire logic [15:0] cur_sr,
    input  wire logic [31:0] cur_sp,
    input  wire logic [31:0] vbr,
    input  wire logic [15:0] exc_sr,
    input  wire logic [15:0] exc_fv,
    input  wire logic [31:0] exc_ipc,
    input  wire logic        exc_six,
    // restored machine state
    output logic             rst_valid,
    output logic      [31:0] rst_pc,
    output logic      [15:0] rst_sr,
    output logic      [31:0] rst_fault_addr,
    output logic      [31:0] rst_dbuf,
    // requeued exceptions
    output logic             rq_trace,
    output logic             rq_bp_hi,
    output logic             rq_bp_lo,
    // rerun cycle
    output logic             rr_req,
    output logic      [31:0] rr_addr,
    output logic             rr_rw,
    output logic      [2:0]  rr_fc,
    output logic      [1:0]  rr_siz,
    output logic      [31:0] rr_data,
    input  wire logic        rr_done,
    output logic             rr_discard,
    // resume actions
    output logic             rs_restart,
    output logic             rs_continue,
    output logic      [7:0]  rs_xfer_cnt,
    output logic      [4:0]  rs_rescan,
    output logic             rs_rebuild,
    output logic      [31:0] rs_vec_addr,
    output logic      [15:0] rb_sr,
    output logic      [15:0] rb_fv,
    output logic      [31:0] rb_ipc,
    output logic             rb_six,
    // revision mismatch on return
    output logic             rev_err
);
    bfr_state_e  state_q;
    bfr_state_e  state_d;
    logic [15:0] frame_q [FRAME_N];
    logic        sp_match_q;
    logic        rev_bad_q;
    logic        go;
    logic [31:0] st_fa;
    logic [31:0] st_pc;
    logic [31:0] st_ipc;
    logic [31:0] st_db;
    logic [31:0] fv_vec;
    logic [31:0] exc_vec;
    bfr_ssw_s    st_ssw;

    bfr_ssw_if sw ();

    bfr_ssw_codec u_codec (
        .sw (sw.codec)
    );

    // a 32-bit value rebuilt from two frame words
    function automatic logic [31:0] fw32(input logic [15:0] hi, input logic [15:0] lo);
        fw32 = {hi, lo};
    endfunction : fw32

    // vector slot address from a format/vector word
    function automatic logic [31:0] vec_of(input logic [31:0] base, input logic [15:0] fv);
        vec_of = base + {20'h00000, fv[11:0]};
    endfunction : vec_of

    assign go     = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO];
    assign st_fa  = fw32(frame_q[FW_FAH], frame_q[FW_FAL]);
    assign st_pc  = fw32(frame_q[FW_PCH], frame_q[FW_PCL]);
    assign st_ipc = fw32(frame_q[FW_IPH], frame_q[FW_IPL]);
    assign st_db  = fw32(frame_q[FW_DBH], frame_q[FW_DBL]);
    assign fv_vec = vec_of(vbr, frame_q[FW_FV]);
    // vector slot of the exception being processed when the fault hit
    assign exc_vec = vec_of(vbr, exc_fv);
    assign sw.unpack_w = frame_q[FW_SSW];
    assign st_ssw      = sw.unpack_f;

    // fields of the status word for the fault being stacked
    always_comb begin
        sw.pack_f     = '0;
        sw.pack_f.tr  = pend_trace;
        sw.pack_f.b1  = pend_bp_hi;
        sw.pack_f.b0  = pend_bp_lo;
        sw.pack_f.fc  = flt_fc;
        sw.pack_f.remaining_size_field = flt_siz;
        // second half of a split long keeps the original size as long
        sw.pack_f.szc = flt_half2 ? SZ_LONG : flt_szc;
        if (flt_exc) begin
            sw.pack_f.tp  = 1'b1;
            sw.pack_f.rw  = 1'b1;
        end else if (flt_multi_register_move) begin
            sw.pack_f.mv  = 1'b1;
            sw.pack_f.rw  = flt_rw;
            sw.pack_f.inf = flt_ifetch;
            sw.pack_f.rr  = !flt_rw;
        end else if (flt_rel_wr) begin
            sw.pack_f.rr  = 1'b1;
        end else begin
            sw.pack_f.rm  = flt_rm;
            sw.pack_f.inf = flt_ifetch;
            sw.pack_f.rw  = flt_rw;
        end
    end

    // sequence: record, hold for the handler, unstack, rerun, resume
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (flt_valid) begin
                    state_d = ST_HELD;
                end
            end
            ST_HELD: begin
                if (go && (frame_q[FW_XC][15:8] == UCODE_REV)) begin
                    state_d = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                state_d = st_ssw.rr ? ST_RERUN : ST_RESUME;
            end
            ST_RERUN: begin
                if (rr_done) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // frame store: hardware stacks on a fault, software edits while held
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < FRAME_N; i++) begin
                frame_q[i] <= WORD_RST;
            end
        end else if ((state_q == ST_IDLE) && flt_valid) begin
            frame_q[FW_SR]  <= cur_sr;
            frame_q[FW_PCH] <= cur_pc[31:16];
            frame_q[FW_PCL] <= cur_pc[15:0];
            frame_q[FW_FV]  <= {FMT_BUSERR, exc_fv[11:0]};
            frame_q[FW_XC]  <= {UCODE_REV, multi_register_move_cnt};
            frame_q[FW_SSW] <= sw.pack_w;
            if (flt_exc && flt_vec_fetch) begin
                // the handler spots a failed vector fetch by this address
                frame_q[FW_FAH] <= exc_vec[31:16];
                frame_q[FW_FAL] <= exc_vec[15:0];
            end else begin
                frame_q[FW_FAH] <= flt_addr[31:16];
                frame_q[FW_FAL] <= flt_addr[15:0];
            end
            if (flt_exc) begin
                frame_q[FW_DBH] <= exc_sr;
                frame_q[FW_DBL] <= exc_fv;
                // four-word faulted frames leave the address slot zero
                frame_q[FW_IPH] <= exc_six ? exc_ipc[31:16] : WORD_RST;
                frame_q[FW_IPL] <= exc_six ? exc_ipc[15:0] : WORD_RST;
            end else begin
                frame_q[FW_DBH] <= flt_dbuf[31:16];
                frame_q[FW_DBL] <= flt_dbuf[15:0];
                frame_q[FW_IPH] <= cur_pc[31:16];
                frame_q[FW_IPL] <= cur_pc[15:0];
            end
        end else if ((state_q == ST_HELD) && reg_wr && (reg_addr < 5'(FRAME_N))) begin
            frame_q[reg_addr[3:0]] <= reg_wdata;
        end
    end

    // frame self-check flags, kept for software
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sp_match_q <= 1'b0;
            rev_bad_q  <= 1'b0;
        end else if ((state_q == ST_HELD) && go) begin
            // frame stacked over a faulted first frame: recovery still runs
            sp_match_q <= (st_fa == cur_sp);
            rev_bad_q  <= (frame_q[FW_XC][15:8] != UCODE_REV);
        end
    end

    // read port: data only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= WORD_RST;
        end else if (!reg_rd) begin
            reg_rdata <= WORD_RST;
        end else if (reg_addr < 5'(FRAME_N)) begin
            reg_rdata <= frame_q[reg_addr[3:0]];
        end else if (reg_addr == REG_STAT) begin
            reg_rdata <= {12'h000, rev_bad_q, sp_match_q, state_q[4:2] != 3'h0,
                          state_q == ST_HELD};
        end else begin
            reg_rdata <= WORD_RST;
        end
    end

    // revision mismatch refuses the return and leaves the frame held
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rev_err <= 1'b0;
        end else begin
            rev_err <= (state_q == ST_HELD) && go && (frame_q[FW_XC][15:8] != UCODE_REV);
        end
    end

    // unstack machine state and requeue pending exceptions
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rst_valid      <= 1'b0;
            rst_pc         <= '0;
            rst_sr         <= WORD_RST;
            rst_fault_addr <= '0;
            rst_dbuf       <= '0;
            rq_trace       <= 1'b0;
            rq_bp_hi       <= 1'b0;
            rq_bp_lo       <= 1'b0;
        end else begin
            rst_valid <= (state_q == ST_RESTORE);
            rq_trace  <= (state_q == ST_RESTORE) && st_ssw.tr;
            rq_bp_hi  <= (state_q == ST_RESTORE) && st_ssw.b1;
            rq_bp_lo  <= (state_q == ST_RESTORE) && st_ssw.b0;
            if (state_q == ST_RESTORE) begin
                rst_pc         <= st_pc;
                rst_sr         <= frame_q[FW_SR];
                rst_fault_addr <= st_fa;
                rst_dbuf       <= st_db;
            end
        end
    end

    // rerun of the released cycle, fields taken exactly as stacked
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rr_req  <= 1'b0;
            rr_addr <= '0;
            rr_rw   <= 1'b0;
            rr_fc   <= 3'h0;
            rr_siz  <= SZ_LONG;
            rr_data <= '0;
        end else if ((state_q == ST_RESTORE) && st_ssw.rr) begin
            // the size is the stacked remaining size field; moving the address back does not change it
            rr_req  <= 1'b1;
            rr_addr <= st_fa;
            rr_siz  <= st_ssw.remaining_size_field;
            rr_rw   <= st_ssw.rw;
            rr_fc   <= st_ssw.fc;
            rr_data <= st_db;
        end else if ((state_q == ST_RERUN) && rr_done) begin
            rr_req <= 1'b0;
        end
    end

    // an edited word may turn the rerun into a read; its data go nowhere
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rr_discard <= 1'b0;
        end else begin
            rr_discard <= (state_q == ST_RERUN) && rr_done && rr_rw;
        end
    end

    // resume: continue a multi-move, rebuild a faulted exception, else restart
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rs_restart  <= 1'b0;
            rs_continue <= 1'b0;
            rs_rebuild  <= 1'b0;
        end else begin
            rs_rebuild  <= (state_q == ST_RESUME) && st_ssw.tp;
            rs_continue <= (state_q == ST_RESUME) && !st_ssw.tp && st_ssw.mv;
            rs_restart  <= (state_q == ST_RESUME) && !st_ssw.tp && !st_ssw.mv;
        end
    end

    // multi-move continuation data: counter reload and rescan count
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rs_xfer_cnt <= 8'h00;
            rs_rescan   <= 5'h00;
        end else if ((state_q == ST_RESUME) && st_ssw.mv) begin
            // the operand address is not recomputed, only the mask is walked
            rs_xfer_cnt <= frame_q[FW_XC][7:0];
            rs_rescan   <= MOVE_SLOTS - frame_q[FW_XC][4:0];
        end
    end

    // faulted exception frame contents and handler vector address
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rs_vec_addr <= '0;
            rb_sr       <= WORD_RST;
            rb_fv       <= WORD_RST;
            rb_ipc      <= '0;
            rb_six      <= 1'b0;
        end else if ((state_q == ST_RESUME) && st_ssw.tp) begin
            rs_vec_addr <= vec_of(vbr, frame_q[FW_DBL]);
            rb_sr       <= frame_q[FW_DBH];
            rb_fv       <= frame_q[FW_DBL];
            rb_ipc      <= st_ipc;
            rb_six      <= frame_q[FW_DBL][15:12] != 4'h0;
        end
    end
endmodule : bfr_fault_recovery

//--- shared/bfr_pkg.sv
// constants and types shared by the bus fault recovery logic
package bfr_pkg;
    // register port
    localparam int unsigned AW       = 5;
    localparam int unsigned DW       = 16;
    localparam int unsigned FRAME_N  = 12;
    localparam logic [4:0]  REG_CTRL = 5'h10;
    localparam logic [4:0]  REG_STAT = 5'h11;
    localparam int unsigned CTRL_GO  = 0;
    // frame word index = byte offset from the stack pointer / 2
    localparam logic [3:0] FW_SR  = 4'h0;
    localparam logic [3:0] FW_PCH = 4'h1;
    localparam logic [3:0] FW_PCL = 4'h2;
    localparam logic [3:0] FW_FV  = 4'h3;
    localparam logic [3:0] FW_FAH = 4'h4;
    localparam logic [3:0] FW_FAL = 4'h5;
    localparam logic [3:0] FW_DBH = 4'h6;
    localparam logic [3:0] FW_DBL = 4'h7;
    localparam logic [3:0] FW_IPH = 4'h8;
    localparam logic [3:0] FW_IPL = 4'h9;
    localparam logic [3:0] FW_XC  = 4'hA;
    localparam logic [3:0] FW_SSW = 4'hB;
    // status word bit positions
    localparam int unsigned B_TP = 15;
    localparam int unsigned B_MV = 14;
    localparam int unsigned B_Z1 = 13;
    localparam int unsigned B_TR = 12;
    localparam int unsigned B_B1 = 11;
    localparam int unsigned B_B0 = 10;
    localparam int unsigned B_RR = 9;
    localparam int unsigned B_RM = 8;
    localparam int unsigned B_IN = 7;
    localparam int unsigned B_RW = 6;
    localparam int unsigned B_Z0 = 5;
    localparam int unsigned B_SZ = 3;
    localparam int unsigned B_FC = 0;
    // remaining size codes
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // frame format code and microcode revision, values arbitrary
    localparam logic [3:0] FMT_BUSERR = 4'hC;
    localparam logic [7:0] UCODE_REV  = 8'h5A;
    // mask slots of the multi-register move
    localparam logic [4:0] MOVE_SLOTS = 5'h10;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    typedef struct packed {
        logic       tp;
        logic       mv;
        logic       tr;
        logic       b1;
        logic       b0;
        logic       rr;
        logic       rm;
        logic       inf;
        logic       rw;
        logic [1:0] szc;
        logic [1:0] remaining_size_field;
        logic [2:0] fc;
    } bfr_ssw_s;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_HELD    = 5'h02,
        ST_RESTORE = 5'h04,
        ST_RERUN   = 5'h08,
        ST_RESUME  = 5'h10
    } bfr_state_e;
endpackage : bfr_pkg

//--- shared/bfr_ssw_if.sv
// status word carrier between the recovery core and its codec
`timescale 1ns/1ns
interface bfr_ssw_if;
    import bfr_pkg::*;
    bfr_ssw_s    pack_f;
    logic [15:0] pack_w;
    logic [15:0] unpack_w;
    bfr_ssw_s    unpack_f;
    modport codec (input pack_f, input unpack_w, output pack_w, output unpack_f);
    modport user  (output pack_f, output unpack_w, input pack_w, input unpack_f);
endinterface : bfr_ssw_if

//--- design/bfr_ssw_codec.sv
// packs and unpacks the fault status word
`timescale 1ns/1ns
module bfr_ssw_codec
    import bfr_pkg::*;
(
    // field side
    bfr_ssw_if.codec sw
);
    // all 16 bits carry a field; the size code is split over bits 13 and 5
    always_comb begin
        sw.pack_w             = WORD_RST;
        sw.pack_w[B_TP]       = sw.pack_f.tp;
        sw.pack_w[B_MV]       = sw.pack_f.mv;
        sw.pack_w[B_Z1]       = sw.pack_f.szc[1];
        sw.pack_w[B_TR]       = sw.pack_f.tr;
        sw.pack_w[B_B1]       = sw.pack_f.b1;
        sw.pack_w[B_B0]       = sw.pack_f.b0;
        sw.pack_w[B_RR]       = sw.pack_f.rr;
        sw.pack_w[B_RM]       = sw.pack_f.rm;
        sw.pack_w[B_IN]       = sw.pack_f.inf;
        sw.pack_w[B_RW]       = sw.pack_f.rw;
        sw.pack_w[B_Z0]       = sw.pack_f.szc[0];
        sw.pack_w[B_SZ+:2]    = sw.pack_f.remaining_size_field;
        sw.pack_w[B_FC+:3]    = sw.pack_f.fc;
    end

    // field split of a stacked word
    always_comb begin
        sw.unpack_f.tp  = sw.unpack_w[B_TP];
        sw.unpack_f.mv  = sw.unpack_w[B_MV];
        sw.unpack_f.tr  = sw.unpack_w[B_TR];
        sw.unpack_f.b1  = sw.unpack_w[B_B1];
        sw.unpack_f.b0  = sw.unpack_w[B_B0];
        sw.unpack_f.rr  = sw.unpack_w[B_RR];
        sw.unpack_f.rm  = sw.unpack_w[B_RM];
        sw.unpack_f.inf = sw.unpack_w[B_IN];
        sw.unpack_f.rw  = sw.unpack_w[B_RW];
        sw.unpack_f.szc = {sw.unpack_w[B_Z1], sw.unpack_w[B_Z0]};
        sw.unpack_f.remaining_size_field = sw.unpack_w[B_SZ+:2];
        sw.unpack_f.fc  = sw.unpack_w[B_FC+:3];
    end
endmodule : bfr_ssw_codec

//--- verification/bfr_chk.sv
// port-level assertions for the recovery core
`timescale 1ns/1ns
module bfr_chk (
    // clock, reset and register port
    input wire logic        mclk, rstn, reg_rd,
    input wire logic [15:0] reg_rdata,
    // restore and rerun
    input wire logic        rst_valid, rq_trace, rq_bp_hi, rq_bp_lo,
    input wire logic        rr_req, rr_rw, rr_done, rr_discard,
    input wire logic [31:0] rr_addr, rst_fault_addr,
    // resume
    input wire logic        rs_restart, rs_continue, rs_rebuild,
    input wire logic [7:0]  rs_xfer_cnt,
    input wire logic [4:0]  rs_rescan
);
    logic rs_any;
    // any of the three resume actions
    assign rs_any = rs_restart | rs_continue | rs_rebuild;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    rr_drop_a: assert property (rr_req && rr_done |=> !rr_req)
        else $error("rerun request not dropped");
    rr_start_a: assert property ($rose(rr_req) |-> rst_valid)
        else $error("rerun outside restore");
    rr_addr_a: assert property (rr_req |-> rr_addr == rst_fault_addr)
        else $error("rerun address differs");
    rr_discard_a: assert property (rr_req && rr_done |=> rr_discard == $past(rr_rw))
        else $error("discard wrong");
    rq_restore_a: assert property (rq_trace || rq_bp_hi || rq_bp_lo |-> rst_valid)
        else $error("requeue outside restore");
    resume_one_a: assert property ($onehot0({rs_restart, rs_continue, rs_rebuild}))
        else $error("two resume actions");
    rescan_cnt_a: assert property (rs_continue |-> rs_rescan == 5'h10 - rs_xfer_cnt[4:0])
        else $error("rescan count wrong");
    plain_resume_a: assert property (rst_valid && !rr_req |=> rs_any)
        else $error("resume late");
    rerun_resume_a: assert property (rr_req && rr_done |=> ##1 rs_any)
        else $error("resume after rerun late");
endmodule : bfr_chk
bind bfr_fault_recovery bfr_chk chk (.*);

//--- verification/bfr_bus_model.sv
// far-side bus controller acking rerun cycles after a set latency
`timescale 1ns/1ns
module bfr_bus_model (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // rerun handshake
    input wire logic       rr_req,
    input wire logic [3:0] lat,
    output logic           rr_done
);
    logic [3:0] wait_q;
    // one-cycle pulse per ack; it clears itself, but a request still held restarts the count and is acked again
    always_ff @(posedge mclk) begin
        if (!rstn || !rr_req || rr_done) begin
            wait_q <= 4'h0;
            rr_done <= 1'b0;
        end else if (wait_q >= lat) begin
            rr_done <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : bfr_bus_model

//--- verification/bfr_fault_recovery_tb_top.sv
// row-driven bench for the recovery core
`timescale 1ns/1ns
module bfr_fault_recovery_tb_top;
    import bfr_pkg::*;
    typedef struct packed {
        logic [2:0]  kind;          // exception, multi-move, released write
        logic        rw;
        logic [1:0]  szc, remaining_size_field, adj;  // adj: handler lowering of the address
        logic [2:0]  act;           // rebuild, continue, restart
        logic [15:0] ssw, nssw;     // stacked word, word after handler edit
    } bfr_row_s;
    bfr_row_s rows [4] = '{'{3'b001, 1'b0, 2'h2, 2'h2, 2'h2, 3'b001, 16'h1611, 16'h1601},
                           '{3'b010, 1'b0, 2'h2, 2'h2, 2'h0, 3'b010, 16'h6212, 16'h6212},
                           '{3'b000, 1'b1, 2'h1, 2'h1, 2'h0, 3'b001, 16'h0C6B, 16'h0E6B},
                           '{3'b100, 1'b0, 2'h0, 2'h0, 2'h0, 3'b100, 16'h9046, 16'h9046}};
    logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, flt_valid = 0, flt_exc = 0, rr_done;
    logic flt_vec_fetch = 0, flt_multi_register_move = 0, flt_rel_wr = 0, flt_half2 = 0, flt_rw = 0;
    logic flt_rm = 0, flt_ifetch = 0, pend_trace = 0, pend_bp_hi = 0, pend_bp_lo = 0;
    logic exc_six = 0, rst_valid, rq_trace, rq_bp_hi, rq_bp_lo, rr_req, rr_rw, rr_discard;
    logic rev_err, rs_restart, rs_continue, rs_rebuild, rb_six, rs, rw_s, disc;
    logic [4:0]  reg_addr = 0, rs_rescan;
    logic [15:0] reg_wdata = 0, cur_sr = 0, exc_sr = 0, exc_fv = 0, reg_rdata, rst_sr, rb_sr;
    logic [15:0] rb_fv, fv;
    logic [31:0] flt_addr = 0, flt_dbuf = 0, cur_pc = 0, cur_sp = 0, vbr = 0, exc_ipc = 0;
    logic [31:0] rst_pc, rst_fault_addr, rst_dbuf, rr_addr, rr_data, rs_vec_addr, rb_ipc;
    logic [31:0] fa, db, vb, ra;
    logic [7:0]  multi_register_move_cnt = 0, rs_xfer_cnt;
    logic [3:0]  lat = 0;
    logic [2:0]  flt_fc = 0, rr_fc, rq, act, fc_s;
    logic [1:0]  flt_szc = 0, flt_siz = 0, rr_siz, sz_s;
    bfr_row_s    r;
    int          error_cnt = 0, comparisons = 0;
    bfr_fault_recovery dut (.*);
    bfr_bus_model bus (.*);
    // 10 MHz clock
    always #50 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        @(posedge mclk); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk); reg_rd <= 1'b0;
        @(negedge mclk); chk(nm, e, {16'h0000, reg_rdata});
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk); reg_wr <= 1'b0;
    endtask : wr
    task automatic pulse;
        @(posedge mclk); flt_valid <= 1'b1;
        @(posedge mclk); flt_valid <= 1'b0;
    endtask : pulse
    task automatic reset;
        @(posedge mclk); rstn <= 1'b0;
        repeat (15) @(posedge mclk);
        rstn <= 1'b1;
    endtask : reset
    task automatic final_report;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // hang guard, far beyond the 145 cycles the run needs
    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        final_report;
    end
    // main sequence: one fault and return per row, then the awkward cases
    initial begin
        reset;
        for (int i = 0; i < 4; i++) begin
            r = rows[i]; vb = 32'h0001_0000 << i; fv = 16'h2018 + i[3:0]; db = 32'hA5A5_0000 + i;
            fa = r.kind[2] ? vb + fv[11:0] : 32'h0040_1230 + i;
            @(posedge mclk);
            {flt_exc, flt_multi_register_move, flt_rel_wr} <= r.kind; flt_vec_fetch <= r.kind[2];
            {flt_rm, flt_ifetch} <= {2{r.kind[2]}}; flt_half2 <= r.kind[0]; flt_rw <= r.rw;
            flt_addr <= fa; flt_dbuf <= db; flt_fc <= r.ssw[2:0]; flt_szc <= r.szc;
            flt_siz <= r.remaining_size_field; {pend_trace, pend_bp_hi, pend_bp_lo} <= r.ssw[12:10];
            multi_register_move_cnt <= 8'h0B + i[3:0]; cur_pc <= 32'h2000 + 4 * i; cur_sr <= 16'h2700 + i[3:0];
            cur_sp <= r.kind[2] ? fa : 32'h8000; vbr <= vb; exc_sr <= 16'h2000 + i[3:0];
            exc_fv <= fv; exc_ipc <= 32'h3000 + i; exc_six <= i[0]; lat <= i[3:0];
            pulse;
            rd(FW_SSW, r.ssw, "ssw");
            rd(REG_STAT, 1, "stat");
            rd(FW_FAL, fa[15:0], "fa_lo");
            if (r.kind[2]) begin
                rd(FW_FAH, fa[31:16], "fa_hi");
                rd(FW_DBH, exc_sr, "sr_0c");
                rd(FW_DBL, fv, "fv_0e");
                rd(FW_IPL, exc_ipc[15:0], "ipc_10");
            end
            wr(FW_SSW, r.nssw);
            wr(FW_FAL, fa[15:0] - r.adj);
            wr(REG_CTRL, 16'h0001);
            rq = 'x; act = 0; rs = 0; disc = 0;
            for (int n = 0; n < 40 && act === 3'h0; n++) begin
                @(negedge mclk);
                if (rst_valid) rq = {rq_trace, rq_bp_hi, rq_bp_lo};
                if (rr_req) {rs, rw_s, sz_s, fc_s, ra} = {1'b1, rr_rw, rr_siz, rr_fc, rr_addr};
                disc |= rr_discard;
                act = {rs_rebuild, rs_continue, rs_restart};
            end
            chk("resume", r.act, act);
            chk("requeue", r.nssw[12:10], rq);
            chk("rerun", r.nssw[9], rs);
            if (rs) begin
                chk("rr_addr", fa - r.adj, ra);
                chk("rr_ctl", {r.nssw[6], r.nssw[4:0]}, {rw_s, sz_s, fc_s});
                chk("discard", r.nssw[6], disc);
            end
            chk("rst_pc", cur_pc, rst_pc);
            chk("rst_sr", cur_sr, rst_sr);
            chk("rst_fa", fa - r.adj, rst_fault_addr);
            chk("rst_db", r.kind[2] ? {exc_sr, fv} : db, rst_dbuf);
            if (act[1]) chk("xfer", multi_register_move_cnt, rs_xfer_cnt);
            if (act[1]) chk("rescan", 16 - (11 + i), rs_rescan);
            if (act[2]) chk("vec", vb + fv[11:0], rs_vec_addr);
            if (act[2]) chk("frame", {exc_sr, fv}, {rb_sr, rb_fv});
            if (act[2]) chk("ipc", exc_ipc, rb_ipc);
            if (act[2]) chk("six", exc_six, rb_six);
            if (rs) chk("rr_data", db, rr_data);
            // the stack pointer match is taken when the return is started
            rd(REG_STAT, {r.kind[2], 2'b00}, "sp_match");
        end
        // a second report while held is ignored; a bad revision refuses the return
        pulse;
        flt_exc <= 1'b0; flt_vec_fetch <= 1'b0; flt_addr <= 32'h0000_0BAD;
        pulse;
        wr(FW_XC, 16'h0000);
        wr(REG_CTRL, 16'h0001);
        @(negedge mclk); chk("rev_err", 1, rev_err);
        rd(REG_STAT, 13, "stat_rev");
        rd(FW_FAL, fa[15:0], "held_fa");
        // reset in mid-run while held, then refused and unmapped accesses
        reset;
        rd(REG_STAT, 0, "stat_rst");
        wr(FW_SR, 16'hBEEF);
        rd(FW_SR, 0, "sr_idle");
        rd(5'h1F, 0, "unmapped");
        final_report;
    end
endmodule : bfr_fault_recovery_tb_top
